/* hw/wkf_defines.svh */
// register indices, field positions and timing counts of the wakeup flag block
`ifndef WKF_DEFINES_SVH
`define WKF_DEFINES_SVH

// register indices; byte address is four times the index
`define WKF_IDX_MODFLAG   10'h007
`define WKF_IDX_FILT      10'h008
`define WKF_IDX_MODEN     10'h00c
`define WKF_IDX_ISTAT     10'h00d
`define WKF_IDX_IMASK     10'h00e

// filter register fields
`define WKF_FLAG_BIT      7
`define WKF_EDGE_HI       6
`define WKF_EDGE_LO       5
`define WKF_RSVD_BIT      4
`define WKF_SEL_HI        3
`define WKF_SEL_LO        0

// edge mode encodings
`define WKF_EDGE_OFF      2'h0
`define WKF_EDGE_RISE     2'h1
`define WKF_EDGE_FALL     2'h2
`define WKF_EDGE_ANY      2'h3

// interrupt status bits
`define WKF_IRQ_MOD_BIT   0
`define WKF_IRQ_FILT_BIT  1

// glitch filter length in low-power oscillator cycles
`define WKF_FILT_TICKS    2'h3

// reset values
`define WKF_RST_BYTE      8'h00
`define WKF_RST_WORD      32'h0000_0000

`endif

/* hw/wkf_pkg.sv */
// types shared by the wakeup flag block
package wkf_pkg;

  typedef enum logic [0:0] {
    WKF_F_IDLE,
    WKF_F_COUNT
  } wkf_fstate_t;

  typedef logic [1:0] wkf_edge_t;
  typedef logic [3:0] wkf_sel_t;

endpackage

/* hw/wkf_sync.sv */
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ns
`default_nettype none
module wkf_sync #(
  parameter int WIDTH = 17
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } wkf_sync_state_t;

  wkf_sync_state_t state;
  wkf_sync_state_t next_state;

  // first stage feeds only the second
  always_comb begin
    next_state.meta   = async_in;
    next_state.stable = state.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.stable;

endmodule // wkf_sync
`default_nettype wire

/* hw/wkf_filter.sv */
// edge detect and glitch filter stepped by low-power oscillator ticks
`timescale 1ns/1ns
`default_nettype none
`include "wkf_defines.svh"
module wkf_filter
  import wkf_pkg::*;
#(
  parameter logic [1:0] TICKS = `WKF_FILT_TICKS
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              tick,
  input  wire logic              restart,
  input  wire logic              pin,
  input  wire wkf_pkg::wkf_edge_t edge_mode,
  output logic                   detect
);
  import wkf_pkg::*;

  typedef struct packed {
    wkf_fstate_t st;
    logic        prev;
    logic        prev_valid;
    logic        target;
    logic [1:0]  cnt;
    logic        detect;
  } wkf_filt_state_t;

  wkf_filt_state_t state;
  wkf_filt_state_t next_state;
  logic            edge_hit;

  // edge match against the previous sample
  always_comb begin
    edge_hit = 1'b0;
    case (edge_mode)
      `WKF_EDGE_RISE: edge_hit = !state.prev && pin; // R7
      `WKF_EDGE_FALL: edge_hit = state.prev && !pin; // R7
      `WKF_EDGE_ANY:  edge_hit = state.prev != pin; // R7
      default:        edge_hit = 1'b0; // R7
    endcase
  end

  // a new config drops history, so the first sample only primes the filter
  always_comb begin
    next_state        = state;
    next_state.detect = 1'b0;
    if (restart || edge_mode == `WKF_EDGE_OFF) begin
      next_state.st         = WKF_F_IDLE; // R12
      next_state.prev_valid = 1'b0;
    end else if (tick) begin
      next_state.prev       = pin;
      next_state.prev_valid = 1'b1;
      case (state.st)
        WKF_F_IDLE: begin
          if (state.prev_valid && edge_hit) begin
            next_state.st     = WKF_F_COUNT;
            next_state.target = pin;
            next_state.cnt    = 2'h1;
          end
        end
        WKF_F_COUNT: begin
          // level must hold for the whole filter length
          if (pin != state.target) begin
            next_state.st = WKF_F_IDLE; // R10
          end else if (state.cnt == TICKS - 2'h1) begin
            next_state.st     = WKF_F_IDLE;
            next_state.detect = 1'b1; // R10
          end else begin
            next_state.cnt = state.cnt + 2'h1;
          end
        end
        default: next_state.st = WKF_F_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign detect = state.detect;

  property p_detect_needs_mode;
    @(posedge pclk) disable iff (!presetn)
    detect |-> $past(edge_mode) != `WKF_EDGE_OFF && $past(tick);
  endproperty
  a_detect_needs_mode: assert property (p_detect_needs_mode) else $error("filter detect while disabled"); // R10

endmodule // wkf_filter
`default_nettype wire

/* hw/wkf_top.sv */
// wakeup module flags and pin filter one, reached over APB
//
// How it works
// R1 - eight module wake flags, one per internal module, set when it caused the exit
// R2 - each flag mirrors its peripheral flag; writing one does not clear it
// R3 - the flagged source drives interrupt flow in stop, reset flow in deep stop
// R4 - both registers reset only by the chip reset not from deep-stop wakeup
// R5 - filter detect flag at bit 7 set when filtered selected pin caused exit
// R6 - writing one clears filter detect flag, writing zero leaves it
// R7 - edge field bits 6-5: off, rising, falling, either edge
// R8 - bit 4 of filter register reads zero, writes ignored
// R9 - pin select bits 3-0 route one of sixteen wake pins into the filter
// R10 - three-cycle glitch filter on oscillator clock; level must hold until timeout
// R11 - up to two sync cycles more, wakeup alert within five cycles total
// R12 - software waits five oscillator cycles after filter config before stopping
// R13 - a module wakes the chip only while its wake enable bit is set
// R14 - detect flag sets only with filter enabled and a low-leakage mode active
`timescale 1ns/1ns
`default_nettype none
`include "wkf_defines.svh"
module wkf_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  periph_wake_flag,
  input  wire logic [15:0] wake_pin,
  input  wire logic        low_power_osc_clock,
  input  wire logic        mode_low_leakage_stop,
  input  wire logic        mode_very_low_leakage_stop,
  output logic             wake_irq_flow,
  output logic             wake_reset_flow,
  output logic             irq
);
  import wkf_pkg::*;

  typedef struct packed {
    logic [7:0]  modflag;
    logic [7:0]  moden;
    logic        fflag;
    wkf_edge_t   edge_mode;
    wkf_sel_t    sel;
    logic [1:0]  istat;
    logic [1:0]  imask;
    logic        lpo_q;
    logic [31:0] rdata;
    logic        slverr;
  } wkf_top_state_t;

  wkf_top_state_t state;
  wkf_top_state_t next_state;

  logic [16:0] synced;
  logic [15:0] pin_s;
  logic        lpo_s;
  logic        lpo_tick;
  logic        filt_pin;
  logic        filt_detect;
  logic        filt_restart;
  logic        mode_active;
  logic [9:0]  idx;
  logic        setup;
  logic        wr_acc;
  logic        rd_acc;
  logic        hit;
  logic [7:0]  filt_reg;
  logic [7:0]  mod_next;
  logic        fset;

  // pins and the oscillator clock come from outside this domain
  wkf_sync #(
    .WIDTH(17)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({low_power_osc_clock, wake_pin}),
    .sync_out (synced)
  );

  assign pin_s    = synced[15:0];
  assign lpo_s    = synced[16];
  assign lpo_tick = lpo_s && !state.lpo_q;

  // selected pin into the single filter
  assign filt_pin = pin_s[state.sel]; // R9

  // a config write that changes edge mode or pin select restarts the filter so it re-primes on the new pin
  assign filt_restart = wr_acc && idx == `WKF_IDX_FILT &&
                        (pwdata[`WKF_EDGE_HI:`WKF_EDGE_LO] != state.edge_mode ||
                         pwdata[`WKF_SEL_HI:`WKF_SEL_LO] != state.sel); // R12

  wkf_filter #(
    .TICKS(`WKF_FILT_TICKS)
  ) u_filter (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick      (lpo_tick),
    .restart   (filt_restart),
    .pin       (filt_pin),
    .edge_mode (state.edge_mode),
    .detect    (filt_detect)
  );

  // bus decode
  assign idx         = paddr[11:2];
  assign setup       = psel && !penable;
  assign wr_acc      = psel && penable && pwrite;
  assign rd_acc      = psel && penable && !pwrite;
  assign mode_active = mode_low_leakage_stop || mode_very_low_leakage_stop;
  assign filt_reg    = {state.fflag, state.edge_mode, 1'b0, state.sel}; // R8

  // gated peripheral flags; no glitch filter on internal modules
  assign mod_next = periph_wake_flag & state.moden; // R1 R13
  assign fset     = filt_detect && mode_active && state.edge_mode != `WKF_EDGE_OFF; // R5 R14

  always_comb begin
    next_state        = state;
    next_state.lpo_q  = lpo_s;
    // mirror only; no bus write can clear these
    next_state.modflag = mod_next; // R2

    // decode in setup so read data and error come from flops
    hit = 1'b1;
    if (idx == `WKF_IDX_MODFLAG) begin
      next_state.rdata = {24'h0, state.modflag};
    end else if (idx == `WKF_IDX_FILT) begin
      next_state.rdata = {24'h0, filt_reg};
    end else if (idx == `WKF_IDX_MODEN) begin
      next_state.rdata = {24'h0, state.moden};
    end else if (idx == `WKF_IDX_ISTAT) begin
      next_state.rdata = {30'h0, state.istat};
    end else if (idx == `WKF_IDX_IMASK) begin
      next_state.rdata = {30'h0, state.imask};
    end else begin
      hit = 1'b0;
      next_state.rdata = `WKF_RST_WORD;
    end
    if (setup) begin
      next_state.slverr = !hit;
    end else begin
      next_state.rdata  = state.rdata;
      next_state.slverr = state.slverr;
    end

    // register writes
    if (wr_acc) begin
      if (idx == `WKF_IDX_FILT) begin
        next_state.edge_mode = pwdata[`WKF_EDGE_HI:`WKF_EDGE_LO]; // R7
        next_state.sel       = pwdata[`WKF_SEL_HI:`WKF_SEL_LO]; // R9
        if (pwdata[`WKF_FLAG_BIT]) begin
          next_state.fflag = 1'b0; // R6
        end
      end else if (idx == `WKF_IDX_MODEN) begin
        next_state.moden = pwdata[7:0];
      end else if (idx == `WKF_IDX_IMASK) begin
        next_state.imask = pwdata[1:0];
      end
    end
    // status clears on read; events below win over the clear
    if (rd_acc && idx == `WKF_IDX_ISTAT) begin
      next_state.istat = 2'h0;
    end

    // hardware set beats a same-cycle software clear
    if (fset) begin
      next_state.fflag = 1'b1; // R5
      next_state.istat[`WKF_IRQ_FILT_BIT] = 1'b1;
    end
    if (|(mod_next & ~state.modflag)) begin
      next_state.istat[`WKF_IRQ_MOD_BIT] = 1'b1;
    end
  end

  // presetn is the chip reset that excludes deep-stop wakeup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0; // R4
    end else begin
      state <= next_state;
    end
  end

  // the flagged source picks the exit flow by mode
  assign wake_irq_flow   = mode_low_leakage_stop && (|state.modflag || state.fflag); // R3
  assign wake_reset_flow = mode_very_low_leakage_stop && (|state.modflag || state.fflag); // R3
  assign irq             = |(state.istat & state.imask);
  assign prdata          = state.rdata;
  assign pslverr         = state.slverr && psel && penable;
  assign pready          = 1'b1;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_flag_mirror;
    ##1 state.modflag == $past(periph_wake_flag & state.moden);
  endproperty
  a_flag_mirror: assert property (p_flag_mirror) else $error("module flag not mirrored"); // R1

  property p_no_w1_clear;
    (wr_acc && idx == `WKF_IDX_MODFLAG && $stable(periph_wake_flag) && $stable(state.moden)) ##1
      $stable(periph_wake_flag) |=> $stable(state.modflag);
  endproperty
  a_no_w1_clear: assert property (p_no_w1_clear) else $error("write changed module flag"); // R2

  property p_flow_lls;
    (mode_low_leakage_stop && |state.modflag) |-> wake_irq_flow && !(wake_reset_flow && !mode_very_low_leakage_stop);
  endproperty
  a_flow_lls: assert property (p_flow_lls) else $error("stop exit not on interrupt flow"); // R3

  property p_flow_very_low_leakage_stop;
    (mode_very_low_leakage_stop && state.fflag) |-> wake_reset_flow;
  endproperty
  a_flow_very_low_leakage_stop: assert property (p_flow_very_low_leakage_stop) else $error("deep stop exit not on reset flow"); // R3

  sequence s_filter_event;
    filt_detect && mode_active && state.edge_mode != `WKF_EDGE_OFF;
  endsequence

  property p_detect_sets;
    s_filter_event |=> state.fflag;
  endproperty
  a_detect_sets: assert property (p_detect_sets) else $error("filter detect flag not set"); // R5

  property p_w1c;
    (wr_acc && idx == `WKF_IDX_FILT && pwdata[`WKF_FLAG_BIT] && !fset) |=> !state.fflag;
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear detect flag"); // R6

  property p_w0_keeps;
    (wr_acc && idx == `WKF_IDX_FILT && !pwdata[`WKF_FLAG_BIT] && state.fflag) |=> state.fflag;
  endproperty
  a_w0_keeps: assert property (p_w0_keeps) else $error("write zero cleared detect flag"); // R6

  property p_reserved_zero;
    (setup && idx == `WKF_IDX_FILT) |=> prdata[`WKF_RSVD_BIT] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit reads one"); // R8

  property p_edge_store;
    (wr_acc && idx == `WKF_IDX_FILT) |=> state.edge_mode == $past(pwdata[`WKF_EDGE_HI:`WKF_EDGE_LO]);
  endproperty
  a_edge_store: assert property (p_edge_store) else $error("edge field not stored"); // R7

  property p_pin_route;
    filt_pin == pin_s[state.sel];
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("wrong pin routed to filter"); // R9

  property p_enable_gate;
    ##1 (state.modflag & ~$past(state.moden)) == 8'h00;
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("disabled module raised its flag"); // R13

  property p_set_only_active;
    (!state.fflag ##1 state.fflag) |-> $past(mode_active) && $past(state.edge_mode) != `WKF_EDGE_OFF;
  endproperty
  a_set_only_active: assert property (p_set_only_active) else $error("detect flag set while inactive"); // R14

  property p_alert_follows;
    s_filter_event |=> wake_irq_flow || wake_reset_flow || !mode_active;
  endproperty
  a_alert_follows: assert property (p_alert_follows) else $error("wakeup alert late"); // R11

  property p_irq_level;
    ##1 irq == |(state.istat & state.imask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  property p_set_beats_clear;
    (fset && wr_acc && idx == `WKF_IDX_FILT && pwdata[`WKF_FLAG_BIT]) |=> state.fflag;
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) else $error("clear beat a same-cycle detect"); // R5

  property p_sel_store;
    (wr_acc && idx == `WKF_IDX_FILT) |=> state.sel == $past(pwdata[`WKF_SEL_HI:`WKF_SEL_LO]);
  endproperty
  a_sel_store: assert property (p_sel_store) else $error("pin select not stored"); // R9

  property p_read_modflag;
    (setup && idx == `WKF_IDX_MODFLAG) |=> prdata == {24'h0, $past(state.modflag)};
  endproperty
  a_read_modflag: assert property (p_read_modflag) else $error("module flag read data wrong"); // R1

  property p_istat_clear;
    (rd_acc && idx == `WKF_IDX_ISTAT && !fset && !(|(mod_next & ~state.modflag))) |=> state.istat == 2'h0;
  endproperty
  a_istat_clear: assert property (p_istat_clear) else $error("status not cleared by read");

  property p_unmapped_err;
    (setup && !hit) |=> state.slverr;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access without error");

endmodule // wkf_top
`default_nettype wire

/* verification/wkf_partner.sv */
// model of wakeup peripherals, external wake pins and the low-power oscillator
`timescale 1ns/1ns
`default_nettype none
module wkf_partner (
  input  wire logic        pclk,
  input  wire logic [7:0]  flag_set,
  input  wire logic [7:0]  flag_clr,
  input  wire logic [15:0] pin_level,
  output logic      [7:0]  periph_wake_flag,
  output logic      [15:0] wake_pin,
  output logic             low_power_osc_clock
);
  // oscillator runs free and out of phase with pclk, 400 ns period
  initial begin
    low_power_osc_clock = 1'b0;
    #7;
    forever #200 low_power_osc_clock = ~low_power_osc_clock;
  end
  // a peripheral flag stays set until cleared inside the peripheral
  initial periph_wake_flag = 8'h00;
  always @(posedge pclk) begin
    periph_wake_flag <= (periph_wake_flag | flag_set) & ~flag_clr;
  end
  // pin levels are held by the bench for as long as a scenario needs
  assign wake_pin = pin_level;
endmodule // wkf_partner
`default_nettype wire

/* verification/tb_wakeup_module_flags_pin_filter.sv */
// self-checking bench for the wakeup flag and pin filter block
`timescale 1ns/1ns
`default_nettype none
`include "wkf_defines.svh"
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_wakeup_module_flags_pin_filter;
  localparam int OSC = 10; // pclk cycles per oscillator cycle
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        low_power_osc_clock, mode_ll, mode_vll, wake_irq_flow, wake_reset_flow, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  periph_wake_flag, flag_set, flag_clr;
  logic [15:0] wake_pin, pin_level;
  int          miscompares = 0;
  int          num_checks = 0;
  int          cycles = 0;

  wkf_top wkf_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_wake_flag(periph_wake_flag), .wake_pin(wake_pin), .low_power_osc_clock(low_power_osc_clock),
    .mode_low_leakage_stop(mode_ll), .mode_very_low_leakage_stop(mode_vll),
    .wake_irq_flow(wake_irq_flow), .wake_reset_flow(wake_reset_flow), .irq(irq));
  wkf_partner wkf_partner_inst (.pclk(pclk), .flag_set(flag_set), .flag_clr(flag_clr), .pin_level(pin_level),
    .periph_wake_flag(periph_wake_flag), .wake_pin(wake_pin), .low_power_osc_clock(low_power_osc_clock));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    if (miscompares == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // hang guard, well above the roughly 1300 cycles the scenarios need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rd_chk(input string nm, input logic [9:0] idx, input logic [31:0] ex);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 32'h0, r, e);
    `CHK(nm, ex, r)
  endtask

  // reset values, unmapped access, and a second reset mid-run
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    rd_chk("modflag rst", `WKF_IDX_MODFLAG, `WKF_RST_WORD);
    rd_chk("filt rst", `WKF_IDX_FILT, `WKF_RST_WORD);
    apb(1'b0, 10'h3ff, 32'h0, r, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, r)
    wr(`WKF_IDX_FILT, 32'h25);
    rd_chk("filt set", `WKF_IDX_FILT, 32'h25);
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    rd_chk("filt rst2", `WKF_IDX_FILT, `WKF_RST_WORD);
  endtask

  // module flags mirror enabled peripheral flags; interrupt masked, unmasked, cleared
  task automatic t_modflag();
    mode_ll <= 1'b1;
    wr(`WKF_IDX_IMASK, 32'h2);
    wr(`WKF_IDX_MODEN, 32'h5a);
    flag_set <= 8'hff;
    cyc(1);
    flag_set <= 8'h00;
    cyc(3);
    rd_chk("modflag", `WKF_IDX_MODFLAG, 32'h5a);
    `CHK("irq masked", 1'b0, irq)
    `CHK("irq flow", 1'b1, wake_irq_flow)
    `CHK("reset flow", 1'b0, wake_reset_flow)
    wr(`WKF_IDX_MODFLAG, 32'hff);
    rd_chk("modflag w1", `WKF_IDX_MODFLAG, 32'h5a);
    wr(`WKF_IDX_IMASK, 32'h3);
    // irq comes from registers that load at the access edge; look one edge later
    cyc(1);
    `CHK("irq on", 1'b1, irq)
    rd_chk("istat", `WKF_IDX_ISTAT, 32'h1);
    cyc(1);
    `CHK("irq clr", 1'b0, irq)
    mode_ll <= 1'b0;
    mode_vll <= 1'b1;
    cyc(2);
    `CHK("irq flow vll", 1'b0, wake_irq_flow)
    `CHK("reset flow vll", 1'b1, wake_reset_flow)
    mode_vll <= 1'b0;
    flag_clr <= 8'hff;
    cyc(1);
    flag_clr <= 8'h00;
    cyc(3);
    rd_chk("modflag clr", `WKF_IDX_MODFLAG, 32'h0);
  endtask

  // configure filter, settle, apply a pin event, judge flag and its clearing
  task automatic t_detect(input string nm, input logic [1:0] em, input logic [3:0] sel, input logic [15:0] lv0,
                          input logic [15:0] lv1, input int hold, input logic [15:0] lv2, input logic ex);
    pin_level <= lv0;
    cyc(4);
    wr(`WKF_IDX_FILT, {24'h0, 1'b1, em, 1'b1, sel});
    cyc(5 * OSC);
    pin_level <= lv1;
    cyc(hold);
    pin_level <= lv2;
    cyc(5 * OSC + 3 - hold);
    rd_chk(nm, `WKF_IDX_FILT, {24'h0, ex, em, 1'b0, sel});
    `CHK("filt irq", ex, irq)
    `CHK("filt flow", ex, wake_irq_flow)
    rd_chk("istat filt", `WKF_IDX_ISTAT, {30'h0, ex, 1'b0});
    wr(`WKF_IDX_FILT, {24'h0, 1'b0, em, 1'b0, sel});
    rd_chk("w0 keeps", `WKF_IDX_FILT, {24'h0, ex, em, 1'b0, sel});
    wr(`WKF_IDX_FILT, {24'h0, 1'b1, em, 1'b0, sel});
    rd_chk("w1 clears", `WKF_IDX_FILT, {24'h0, 1'b0, em, 1'b0, sel});
    wr(`WKF_IDX_FILT, 32'h0);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    flag_set = 8'h00;
    flag_clr = 8'h00;
    pin_level = 16'h0000;
    mode_ll = 1'b0;
    mode_vll = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_modflag();
    wr(`WKF_IDX_FILT, 32'hff);
    rd_chk("filt fields", `WKF_IDX_FILT, 32'h6f);
    wr(`WKF_IDX_FILT, 32'h0);
    mode_ll <= 1'b1;
    t_detect("rise p0", `WKF_EDGE_RISE, 4'h0, 16'h0000, 16'h0001, 1, 16'h0001, 1'b1);
    t_detect("fall p15", `WKF_EDGE_FALL, 4'hf, 16'hffff, 16'h7fff, 1, 16'h7fff, 1'b1);
    t_detect("any rise", `WKF_EDGE_ANY, 4'h7, 16'h0000, 16'h0080, 1, 16'h0080, 1'b1);
    t_detect("any fall", `WKF_EDGE_ANY, 4'h9, 16'h0200, 16'h0000, 1, 16'h0000, 1'b1);
    t_detect("wrong edge", `WKF_EDGE_RISE, 4'h2, 16'h0004, 16'h0000, 1, 16'h0000, 1'b0);
    t_detect("other pin", `WKF_EDGE_RISE, 4'h3, 16'h0000, 16'h0010, 1, 16'h0010, 1'b0);
    t_detect("off", `WKF_EDGE_OFF, 4'h5, 16'h0000, 16'h0020, 1, 16'h0020, 1'b0);
    t_detect("glitch", `WKF_EDGE_RISE, 4'h6, 16'h0000, 16'h0040, 6, 16'h0000, 1'b0);
    mode_ll <= 1'b0;
    t_detect("no mode", `WKF_EDGE_RISE, 4'h1, 16'h0000, 16'h0002, 1, 16'h0002, 1'b0);
    tally_and_finish();
  end
endmodule // tb_wakeup_module_flags_pin_filter
`default_nettype wire
